// ===== hdl/bfsu_defines.svh
`ifndef BFSU_DEFINES_SVH
`define BFSU_DEFINES_SVH

// ----------------------------------------------------------------
// Status register bit positions, fixed by the core
// ----------------------------------------------------------------
`define BFSU_FLAG_C      3'h0
`define BFSU_FLAG_Z      3'h1
`define BFSU_FLAG_N      3'h2
`define BFSU_FLAG_V      3'h3
`define BFSU_FLAG_S      3'h4
`define BFSU_FLAG_H      3'h5
`define BFSU_FLAG_T      3'h6
`define BFSU_FLAG_I      3'h7

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define BFSU_STATUS_RESET 8'h00
`define BFSU_RESULT_RESET 8'h00
`define BFSU_OP_CYCLES    1

`endif

// ===== hdl/bfsu_pkg.sv
package bfsu_pkg;

    // ----------------------------------------------------------------
    // Operation codes issued by the decoder
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NOP               = 5'h00,
        OP_ROTATE_LEFT_CARRY = 5'h01,
        OP_ROTATE_RIGHT_CARRY= 5'h02,
        OP_ARITH_SHIFT_RIGHT = 5'h03,
        OP_NIBBLE_SWAP       = 5'h04,
        OP_FLAG_SET_INDEXED  = 5'h05,
        OP_FLAG_CLEAR_INDEXED= 5'h06,
        OP_BIT_TO_TRANSFER   = 5'h07,
        OP_TRANSFER_TO_BIT   = 5'h08,
        OP_CARRY_SET         = 5'h09,
        OP_CARRY_CLEAR       = 5'h0a,
        OP_NEGATIVE_SET      = 5'h0b,
        OP_NEGATIVE_CLEAR    = 5'h0c,
        OP_ZERO_SET          = 5'h0d,
        OP_ZERO_CLEAR        = 5'h0e,
        OP_IRQ_ENABLE        = 5'h0f,
        OP_IRQ_DISABLE       = 5'h10,
        OP_SIGN_SET          = 5'h11,
        OP_SIGN_CLEAR        = 5'h12,
        OP_OVERFLOW_SET      = 5'h13,
        OP_OVERFLOW_CLEAR    = 5'h14,
        OP_TRANSFER_SET      = 5'h15,
        OP_TRANSFER_CLEAR    = 5'h16
    } bfsu_op_type;

    typedef logic [7:0] bfsu_byte_type;
    typedef logic [2:0] bfsu_index_type;

endpackage : bfsu_pkg

// ===== hdl/bfsu_shifter.sv
`timescale 1ns/100ps

module bfsu_shifter (
    input  wire bfsu_pkg::bfsu_op_type   i_op,
    input  wire bfsu_pkg::bfsu_byte_type i_data,
    input  wire logic                    i_carry,
    output bfsu_pkg::bfsu_byte_type      o_result,
    output logic                         o_carry,
    output logic                         o_flags_upd
);

    // ----------------------------------------------------------------
    // Rotate, shift and swap, purely combinational
    // ----------------------------------------------------------------
    always_comb begin
        o_result    = i_data;
        o_carry     = i_carry;
        o_flags_upd = 1'b0;
        case (i_op)
            bfsu_pkg::OP_ROTATE_LEFT_CARRY: begin
                o_result    = {i_data[6:0], i_carry};
                o_carry     = i_data[7];
                o_flags_upd = 1'b1;
            end
            bfsu_pkg::OP_ROTATE_RIGHT_CARRY: begin
                o_result    = {i_carry, i_data[7:1]};
                o_carry     = i_data[0];
                o_flags_upd = 1'b1;
            end
            bfsu_pkg::OP_ARITH_SHIFT_RIGHT: begin
                // Sign bit kept, low bit falls into carry
                o_result    = {i_data[7], i_data[7:1]};
                o_carry     = i_data[0];
                o_flags_upd = 1'b1;
            end
            bfsu_pkg::OP_NIBBLE_SWAP: begin
                o_result = {i_data[3:0], i_data[7:4]};
            end
            default: begin
                o_result = i_data;
            end
        endcase
    end

endmodule : bfsu_shifter

// ===== hdl/bfsu_bit_field.sv
`timescale 1ns/100ps

module bfsu_bit_field (
    input  wire bfsu_pkg::bfsu_byte_type  i_data,
    input  wire bfsu_pkg::bfsu_index_type i_index,
    input  wire logic                     i_bit,
    output logic                          o_bit,
    output bfsu_pkg::bfsu_byte_type       o_inserted
);

    // ----------------------------------------------------------------
    // Single bit pick and single bit replace
    // ----------------------------------------------------------------
    function automatic bfsu_pkg::bfsu_byte_type bit_mask(
        input bfsu_pkg::bfsu_index_type idx);
        bit_mask = 8'h01 << idx;
    endfunction : bit_mask

    always_comb begin
        o_bit      = i_data[i_index];
        o_inserted = (i_data & ~bit_mask(i_index)) |
                     ({8{i_bit}} & bit_mask(i_index));
    end

endmodule : bfsu_bit_field

// ===== hdl/bfsu_unit.sv
`timescale 1ns/100ps
`include "bfsu_defines.svh"

// Summary of operation
// - Rotate left through carry, one clock.
// - Rotate right through carry via old bit 0.
// - Arithmetic shift right keeps bit seven.
// - Shifts update Z,C,N,V; swap touches none.
// - Swap exchanges upper and lower nibbles.
// - Indexed set/clear writes only chosen flag.
// - Source bit copied into transfer flag.
// - Transfer flag copied into destination bit.
// - Carry set and clear instructions.
// - Negative set and clear instructions.
// - Zero set and clear instructions.
// - Interrupt enable sets, disable clears flag.
// - Sign set and clear instructions.
// - Overflow set and clear instructions.
// - Transfer set forces transfer flag high.
// - Transfer clear forces transfer flag low.
module bfsu_unit (
    input  wire logic                     i_mclk,
    input  wire logic                     i_reset,
    input  wire logic                     i_op_valid,
    input  wire bfsu_pkg::bfsu_op_type    i_opcode,
    input  wire bfsu_pkg::bfsu_byte_type  i_dest_data,
    input  wire bfsu_pkg::bfsu_byte_type  i_source_data,
    input  wire bfsu_pkg::bfsu_index_type i_bit_index,
    output bfsu_pkg::bfsu_byte_type       o_result,
    output logic                          o_result_we,
    output bfsu_pkg::bfsu_byte_type       o_status_register
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic bfsu_pkg::bfsu_byte_type flag_put(
        input bfsu_pkg::bfsu_byte_type  value,
        input bfsu_pkg::bfsu_index_type idx,
        input logic                     bit_val);
        bfsu_pkg::bfsu_byte_type mask;
        mask     = 8'h01 << idx;
        flag_put = (value & ~mask) | ({8{bit_val}} & mask);
    endfunction : flag_put

    function automatic logic writes_dest(input bfsu_pkg::bfsu_op_type op);
        case (op)
            bfsu_pkg::OP_ROTATE_LEFT_CARRY,
            bfsu_pkg::OP_ROTATE_RIGHT_CARRY,
            bfsu_pkg::OP_ARITH_SHIFT_RIGHT,
            bfsu_pkg::OP_NIBBLE_SWAP,
            bfsu_pkg::OP_TRANSFER_TO_BIT: writes_dest = 1'b1;
            default:                      writes_dest = 1'b0;
        endcase
    endfunction : writes_dest

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    bfsu_pkg::bfsu_byte_type status_reg;
    bfsu_pkg::bfsu_byte_type status_next;
    bfsu_pkg::bfsu_byte_type result_reg;
    bfsu_pkg::bfsu_byte_type result_next;
    logic                    result_we_reg;
    logic                    result_we_next;

    bfsu_pkg::bfsu_byte_type shift_result;
    logic                    shift_carry;
    logic                    shift_flags_upd;
    logic                    picked_bit;
    bfsu_pkg::bfsu_byte_type loaded_data;
    logic                    neg_bit;

    // ----------------------------------------------------------------
    // Datapath pieces
    // ----------------------------------------------------------------
    bfsu_shifter u_shifter (
        .i_op        (i_opcode),
        .i_data      (i_dest_data),
        .i_carry     (status_reg[`BFSU_FLAG_C]),
        .o_result    (shift_result),
        .o_carry     (shift_carry),
        .o_flags_upd (shift_flags_upd)
    );

    // Same index port serves bit pick from source and bit insert into dest
    bfsu_bit_field u_bit_src (
        .i_data     (i_source_data),
        .i_index    (i_bit_index),
        .i_bit      (1'b0),
        .o_bit      (picked_bit),
        .o_inserted ()
    );

    bfsu_bit_field u_bit_dst (
        .i_data     (i_dest_data),
        .i_index    (i_bit_index),
        .i_bit      (status_reg[`BFSU_FLAG_T]),
        .o_bit      (),
        .o_inserted (loaded_data)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        status_next    = status_reg;
        result_next    = result_reg;
        result_we_next = 1'b0;
        neg_bit        = shift_result[7];
        if (i_op_valid) begin
            result_we_next = writes_dest(i_opcode);
            case (i_opcode)
                bfsu_pkg::OP_ROTATE_LEFT_CARRY,
                bfsu_pkg::OP_ROTATE_RIGHT_CARRY,
                bfsu_pkg::OP_ARITH_SHIFT_RIGHT,
                bfsu_pkg::OP_NIBBLE_SWAP: begin
                    result_next = shift_result;
                    // Swap leaves shift_flags_upd low, so no flag moves
                    if (shift_flags_upd) begin
                        status_next[`BFSU_FLAG_C] = shift_carry;
                        status_next[`BFSU_FLAG_Z] = (shift_result == 8'h00);
                        status_next[`BFSU_FLAG_N] = neg_bit;
                        status_next[`BFSU_FLAG_V] = neg_bit ^ shift_carry;
                    end
                end
                bfsu_pkg::OP_FLAG_SET_INDEXED:
                    status_next = flag_put(status_reg, i_bit_index, 1'b1);
                bfsu_pkg::OP_FLAG_CLEAR_INDEXED:
                    status_next = flag_put(status_reg, i_bit_index, 1'b0);
                bfsu_pkg::OP_BIT_TO_TRANSFER:
                    status_next[`BFSU_FLAG_T] = picked_bit;
                bfsu_pkg::OP_TRANSFER_TO_BIT:
                    result_next = loaded_data;
                bfsu_pkg::OP_CARRY_SET:
                    status_next[`BFSU_FLAG_C] = 1'b1;
                bfsu_pkg::OP_CARRY_CLEAR:
                    status_next[`BFSU_FLAG_C] = 1'b0;
                bfsu_pkg::OP_NEGATIVE_SET:
                    status_next[`BFSU_FLAG_N] = 1'b1;
                bfsu_pkg::OP_NEGATIVE_CLEAR:
                    status_next[`BFSU_FLAG_N] = 1'b0;
                bfsu_pkg::OP_ZERO_SET:
                    status_next[`BFSU_FLAG_Z] = 1'b1;
                bfsu_pkg::OP_ZERO_CLEAR:
                    status_next[`BFSU_FLAG_Z] = 1'b0;
                bfsu_pkg::OP_IRQ_ENABLE:
                    status_next[`BFSU_FLAG_I] = 1'b1;
                bfsu_pkg::OP_IRQ_DISABLE:
                    status_next[`BFSU_FLAG_I] = 1'b0;
                bfsu_pkg::OP_SIGN_SET:
                    status_next[`BFSU_FLAG_S] = 1'b1;
                bfsu_pkg::OP_SIGN_CLEAR:
                    status_next[`BFSU_FLAG_S] = 1'b0;
                bfsu_pkg::OP_OVERFLOW_SET:
                    status_next[`BFSU_FLAG_V] = 1'b1;
                bfsu_pkg::OP_OVERFLOW_CLEAR:
                    status_next[`BFSU_FLAG_V] = 1'b0;
                bfsu_pkg::OP_TRANSFER_SET:
                    status_next[`BFSU_FLAG_T] = 1'b1;
                bfsu_pkg::OP_TRANSFER_CLEAR:
                    status_next[`BFSU_FLAG_T] = 1'b0;
                default: begin
                    status_next = status_reg;
                end
            endcase
        end
    end

    // Every operation retires at the next edge, no stall path
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            status_reg    <= `BFSU_STATUS_RESET;
            result_reg    <= `BFSU_RESULT_RESET;
            result_we_reg <= 1'b0;
        end else begin
            status_reg    <= status_next;
            result_reg    <= result_next;
            result_we_reg <= result_we_next;
        end
    end

    assign o_status_register = status_reg;
    assign o_result          = result_reg;
    assign o_result_we       = result_we_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);

    rotl_result_a: assert property (
        i_op_valid && i_opcode == bfsu_pkg::OP_ROTATE_LEFT_CARRY
        |=> o_result_we
            && o_result == {$past(i_dest_data[6:0]), $past(status_reg[0])}
            && o_status_register[`BFSU_FLAG_C] == $past(i_dest_data[7]))
        else $error("rotate left result or carry wrong");

    rotr_result_a: assert property (
        i_op_valid && i_opcode == bfsu_pkg::OP_ROTATE_RIGHT_CARRY
        |=> o_result == {$past(status_reg[0]), $past(i_dest_data[7:1])}
            && o_status_register[`BFSU_FLAG_C] == $past(i_dest_data[0]))
        else $error("rotate right result or carry wrong");

    asr_result_a: assert property (
        i_op_valid && i_opcode == bfsu_pkg::OP_ARITH_SHIFT_RIGHT
        |=> o_result[7] == $past(i_dest_data[7])
            && o_result[6:0] == $past(i_dest_data[7:1]))
        else $error("arithmetic shift lost sign or order");

    shift_flags_a: assert property (
        i_op_valid && i_opcode inside {bfsu_pkg::OP_ROTATE_LEFT_CARRY,
            bfsu_pkg::OP_ROTATE_RIGHT_CARRY, bfsu_pkg::OP_ARITH_SHIFT_RIGHT}
        |=> o_status_register[`BFSU_FLAG_Z] == (o_result == 8'h00)
            && o_status_register[`BFSU_FLAG_N] == o_result[7]
            && o_status_register[`BFSU_FLAG_V] ==
               (o_result[7] ^ o_status_register[`BFSU_FLAG_C])
            && o_status_register[7:4] == $past(status_reg[7:4]))
        else $error("shift flags not derived from result");

    swap_result_a: assert property (
        i_op_valid && i_opcode == bfsu_pkg::OP_NIBBLE_SWAP
        |=> o_result == {$past(i_dest_data[3:0]), $past(i_dest_data[7:4])})
        else $error("nibble swap result wrong");

    swap_flags_a: assert property (
        i_op_valid && i_opcode == bfsu_pkg::OP_NIBBLE_SWAP
        |=> $stable(o_status_register))
        else $error("nibble swap changed a flag");

    idx_set_a: assert property (
        i_op_valid && i_opcode == bfsu_pkg::OP_FLAG_SET_INDEXED
        |=> o_status_register ==
            ($past(status_reg) | (8'h01 << $past(i_bit_index))))
        else $error("indexed flag set wrong");

    idx_clear_a: assert property (
        i_op_valid && i_opcode == bfsu_pkg::OP_FLAG_CLEAR_INDEXED
        |=> o_status_register ==
            ($past(status_reg) & ~(8'h01 << $past(i_bit_index))))
        else $error("indexed flag clear wrong");

    bit_store_a: assert property (
        i_op_valid && i_opcode == bfsu_pkg::OP_BIT_TO_TRANSFER
        |=> o_status_register[`BFSU_FLAG_T] == $past(i_source_data[i_bit_index])
            && o_status_register[5:0] == $past(status_reg[5:0])
            && o_status_register[7] == $past(status_reg[7]))
        else $error("bit store wrong or disturbed other flags");

    bit_load_a: assert property (
        i_op_valid && i_opcode == bfsu_pkg::OP_TRANSFER_TO_BIT
        |=> o_result_we && $stable(o_status_register)
            && o_result[$past(i_bit_index)] == o_status_register[`BFSU_FLAG_T]
            && ((o_result ^ $past(i_dest_data)) & ~(8'h01 << $past(i_bit_index))) == 8'h00)
        else $error("bit load result wrong");

    carry_ops_a: assert property (
        i_op_valid && i_opcode == bfsu_pkg::OP_CARRY_SET
        |=> o_status_register[`BFSU_FLAG_C]
            && o_status_register[7:1] == $past(status_reg[7:1]))
        else $error("carry set missed");

    carry_clr_a: assert property (
        i_op_valid && i_opcode == bfsu_pkg::OP_CARRY_CLEAR
        |=> !o_status_register[`BFSU_FLAG_C]
            && o_status_register[7:1] == $past(status_reg[7:1]))
        else $error("carry clear wrong");

    negative_ops_a: assert property (
        i_op_valid && i_opcode inside {bfsu_pkg::OP_NEGATIVE_SET,
                                       bfsu_pkg::OP_NEGATIVE_CLEAR}
        |=> o_status_register[`BFSU_FLAG_N] ==
            ($past(i_opcode) == bfsu_pkg::OP_NEGATIVE_SET))
        else $error("negative flag op wrong");

    zero_ops_a: assert property (
        i_op_valid && i_opcode inside {bfsu_pkg::OP_ZERO_SET,
                                       bfsu_pkg::OP_ZERO_CLEAR}
        |=> o_status_register[`BFSU_FLAG_Z] ==
            ($past(i_opcode) == bfsu_pkg::OP_ZERO_SET))
        else $error("zero flag op wrong");

    irq_ops_a: assert property (
        i_op_valid && i_opcode inside {bfsu_pkg::OP_IRQ_ENABLE,
                                       bfsu_pkg::OP_IRQ_DISABLE}
        |=> o_status_register[`BFSU_FLAG_I] ==
            ($past(i_opcode) == bfsu_pkg::OP_IRQ_ENABLE))
        else $error("interrupt flag op wrong");

    sign_ops_a: assert property (
        i_op_valid && i_opcode inside {bfsu_pkg::OP_SIGN_SET,
                                       bfsu_pkg::OP_SIGN_CLEAR}
        |=> o_status_register[`BFSU_FLAG_S] ==
            ($past(i_opcode) == bfsu_pkg::OP_SIGN_SET))
        else $error("sign flag op wrong");

    overflow_ops_a: assert property (
        i_op_valid && i_opcode inside {bfsu_pkg::OP_OVERFLOW_SET,
                                       bfsu_pkg::OP_OVERFLOW_CLEAR}
        |=> o_status_register[`BFSU_FLAG_V] ==
            ($past(i_opcode) == bfsu_pkg::OP_OVERFLOW_SET))
        else $error("overflow flag op wrong");

    tset_a: assert property (
        i_op_valid && i_opcode == bfsu_pkg::OP_TRANSFER_SET
        |=> o_status_register[`BFSU_FLAG_T])
        else $error("transfer set missed");

    tclr_a: assert property (
        i_op_valid && i_opcode == bfsu_pkg::OP_TRANSFER_CLEAR
        |=> !o_status_register[`BFSU_FLAG_T])
        else $error("transfer clear missed");

    idle_hold_a: assert property (
        !i_op_valid |=> !o_result_we && $stable(o_status_register)
                        && $stable(o_result))
        else $error("state moved without an operation");

    rotl_chain_c: cover property (
        i_op_valid && i_opcode == bfsu_pkg::OP_ROTATE_LEFT_CARRY
        ##1 i_op_valid && i_opcode == bfsu_pkg::OP_ROTATE_LEFT_CARRY);
    idx_set_c: cover property (
        i_op_valid && i_opcode == bfsu_pkg::OP_FLAG_SET_INDEXED
        && i_bit_index == 3'h7);
    transfer_move_c: cover property (
        i_op_valid && i_opcode == bfsu_pkg::OP_BIT_TO_TRANSFER
        ##1 i_op_valid && i_opcode == bfsu_pkg::OP_TRANSFER_TO_BIT);

endmodule : bfsu_unit

// ===== test/bfsu_core_model.sv
`timescale 1ns/100ps

module bfsu_core_model (
    input  wire logic                    i_mclk,
    input  wire logic                    i_load,
    input  wire bfsu_pkg::bfsu_byte_type i_load_data,
    input  wire bfsu_pkg::bfsu_byte_type i_result,
    input  wire logic                    i_result_we,
    output bfsu_pkg::bfsu_byte_type      o_dest_data
);
    bfsu_pkg::bfsu_byte_type work_reg = 8'h00;

    // ----------------------------------------------------------------
    // Register file with write-back forwarding
    // ----------------------------------------------------------------
    // Forwarding so a back-to-back instruction reads the fresh result
    assign o_dest_data = i_result_we ? i_result : work_reg;

    always @(posedge i_mclk) begin
        if (i_load) begin
            work_reg <= i_load_data;
        end else if (i_result_we) begin
            work_reg <= i_result;
        end
    end
endmodule : bfsu_core_model

// ===== test/tb_top.sv
`timescale 1ns/100ps
`include "bfsu_defines.svh"

module tb_top;
    logic                     i_mclk        = 1'b0;
    logic                     i_reset       = 1'b1;
    logic                     i_op_valid    = 1'b0;
    bfsu_pkg::bfsu_op_type    i_opcode      = bfsu_pkg::OP_NOP;
    bfsu_pkg::bfsu_byte_type  i_dest_data;
    bfsu_pkg::bfsu_byte_type  i_source_data = 8'h00;
    bfsu_pkg::bfsu_index_type i_bit_index   = 3'h0;
    bfsu_pkg::bfsu_byte_type  o_result;
    logic                     o_result_we;
    bfsu_pkg::bfsu_byte_type  o_status_register;
    logic                     load          = 1'b0;
    logic [7:0]               load_data     = 8'h00;
    logic [7:0]               exp_sr        = 8'h00;
    int                       n_fail        = 0;
    int                       n_checks      = 0;
    localparam logic [2:0] DED_FLAG [7] = '{`BFSU_FLAG_C, `BFSU_FLAG_N, `BFSU_FLAG_Z, `BFSU_FLAG_I,
                                            `BFSU_FLAG_S, `BFSU_FLAG_V, `BFSU_FLAG_T};

    always #5 i_mclk = ~i_mclk;

    bfsu_unit i_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_op_valid(i_op_valid), .i_opcode(i_opcode),
                     .i_dest_data(i_dest_data), .i_source_data(i_source_data), .i_bit_index(i_bit_index),
                     .o_result(o_result), .o_result_we(o_result_we), .o_status_register(o_status_register));

    bfsu_core_model i_core (.i_mclk(i_mclk), .i_load(load), .i_load_data(load_data), .i_result(o_result),
                            .i_result_we(o_result_we), .o_dest_data(i_dest_data));

    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // Expected outcome, kept in exp_sr; carry-in is the flag before the op
    task automatic predict(input bfsu_pkg::bfsu_op_type op, input logic [7:0] d, s, input logic [2:0] b,
                           output logic [7:0] res, output logic we);
        logic c;
        res = d;
        we = 1'b1;
        c = exp_sr[`BFSU_FLAG_C];
        case (op)
            bfsu_pkg::OP_ROTATE_LEFT_CARRY:  {c, res} = {d, c};
            bfsu_pkg::OP_ROTATE_RIGHT_CARRY: {res, c} = {c, d};
            bfsu_pkg::OP_ARITH_SHIFT_RIGHT:  {res, c} = {d[7], d};
            bfsu_pkg::OP_NIBBLE_SWAP:        res = {d[3:0], d[7:4]};
            bfsu_pkg::OP_TRANSFER_TO_BIT:    res[b] = exp_sr[`BFSU_FLAG_T];
            default: begin
                we = 1'b0;
                if (op == bfsu_pkg::OP_FLAG_SET_INDEXED || op == bfsu_pkg::OP_FLAG_CLEAR_INDEXED) begin
                    exp_sr[b] = (op == bfsu_pkg::OP_FLAG_SET_INDEXED);
                end else if (op == bfsu_pkg::OP_BIT_TO_TRANSFER) begin
                    exp_sr[`BFSU_FLAG_T] = s[b];
                end else if (op >= bfsu_pkg::OP_CARRY_SET) begin
                    // Dedicated ops come in set/clear pairs, set on the odd code
                    exp_sr[DED_FLAG[(op - 5'h09) >> 1]] = op[0];
                end
            end
        endcase
        if (op inside {bfsu_pkg::OP_ROTATE_LEFT_CARRY, bfsu_pkg::OP_ROTATE_RIGHT_CARRY,
                       bfsu_pkg::OP_ARITH_SHIFT_RIGHT}) begin
            exp_sr[`BFSU_FLAG_C] = c;
            exp_sr[`BFSU_FLAG_N] = res[7];
            exp_sr[`BFSU_FLAG_Z] = (res == 8'h00);
            exp_sr[`BFSU_FLAG_V] = res[7] ^ c;
        end
    endtask : predict

    task automatic issue(input bfsu_pkg::bfsu_op_type op, input logic [7:0] s, input logic [2:0] b);
        i_op_valid = 1'b1;
        i_opcode = op;
        i_source_data = s;
        i_bit_index = b;
    endtask : issue

    task automatic expect_out(input logic [7:0] res, input logic we);
        check("result_we", {7'h00, o_result_we}, {7'h00, we});
        if (we) begin
            check("result", o_result, res);
        end
        check("status", o_status_register, exp_sr);
    endtask : expect_out

    task automatic run_op(input bfsu_pkg::bfsu_op_type op, input logic [7:0] d, s, input logic [2:0] b);
        logic [7:0] res;
        logic       we;
        predict(op, d, s, b, res, we);
        @(negedge i_mclk);
        load = 1'b1;
        load_data = d;
        @(negedge i_mclk);
        load = 1'b0;
        issue(op, s, b);
        @(negedge i_mclk);
        i_op_valid = 1'b0;
        expect_out(res, we);
    endtask : run_op

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_shifts;
        run_op(bfsu_pkg::OP_ROTATE_LEFT_CARRY, 8'h81, 8'h00, 3'h0);
        run_op(bfsu_pkg::OP_ROTATE_LEFT_CARRY, 8'h7f, 8'h00, 3'h0);
        run_op(bfsu_pkg::OP_ROTATE_RIGHT_CARRY, 8'h01, 8'h00, 3'h0);
        run_op(bfsu_pkg::OP_ROTATE_RIGHT_CARRY, 8'h80, 8'h00, 3'h0);
        run_op(bfsu_pkg::OP_ARITH_SHIFT_RIGHT, 8'h81, 8'h00, 3'h0);
        run_op(bfsu_pkg::OP_ARITH_SHIFT_RIGHT, 8'h01, 8'h00, 3'h0);
        run_op(bfsu_pkg::OP_ARITH_SHIFT_RIGHT, 8'h40, 8'h00, 3'h0);
        run_op(bfsu_pkg::OP_NIBBLE_SWAP, 8'ha5, 8'h00, 3'h0);
    endtask : t_shifts

    task automatic t_flags;
        for (int i = 0; i < 8; i++) begin
            run_op(bfsu_pkg::OP_FLAG_SET_INDEXED, 8'h3c, 8'h00, 3'(i));
        end
        run_op(bfsu_pkg::OP_NIBBLE_SWAP, 8'h00, 8'h00, 3'h0);
        for (int i = 0; i < 8; i++) begin
            run_op(bfsu_pkg::OP_FLAG_CLEAR_INDEXED, 8'h3c, 8'h00, 3'(i));
        end
        for (int k = 9; k <= 22; k++) begin
            run_op(bfsu_pkg::bfsu_op_type'(5'(k)), 8'h55, 8'h00, 3'h0);
        end
        run_op(bfsu_pkg::OP_NOP, 8'h12, 8'hff, 3'h6);
    endtask : t_flags

    task automatic t_bits;
        run_op(bfsu_pkg::OP_BIT_TO_TRANSFER, 8'h00, 8'h08, 3'h3);
        run_op(bfsu_pkg::OP_TRANSFER_TO_BIT, 8'h00, 8'h00, 3'h7);
        run_op(bfsu_pkg::OP_BIT_TO_TRANSFER, 8'hff, 8'hf7, 3'h3);
        run_op(bfsu_pkg::OP_TRANSFER_TO_BIT, 8'hff, 8'h00, 3'h0);
    endtask : t_bits

    task automatic t_back_to_back;
        logic [7:0] r1;
        logic [7:0] r2;
        logic       we;
        run_op(bfsu_pkg::OP_CARRY_CLEAR, 8'h81, 8'h00, 3'h0);
        predict(bfsu_pkg::OP_ROTATE_LEFT_CARRY, 8'h81, 8'h00, 3'h0, r1, we);
        @(negedge i_mclk);
        issue(bfsu_pkg::OP_ROTATE_LEFT_CARRY, 8'h00, 3'h0);
        @(negedge i_mclk);
        expect_out(r1, 1'b1);
        predict(bfsu_pkg::OP_ROTATE_LEFT_CARRY, r1, 8'h00, 3'h0, r2, we);
        @(negedge i_mclk);
        i_op_valid = 1'b0;
        expect_out(r2, 1'b1);
    endtask : t_back_to_back

    task automatic t_reset_mid_run;
        run_op(bfsu_pkg::OP_FLAG_SET_INDEXED, 8'h00, 8'h00, 3'h7);
        @(negedge i_mclk);
        i_reset = 1'b1;
        repeat (2) @(negedge i_mclk);
        i_reset = 1'b0;
        exp_sr = `BFSU_STATUS_RESET;
        expect_out(`BFSU_RESULT_RESET, 1'b0);
        check("result", o_result, `BFSU_RESULT_RESET);
        // First instruction after a mid-run reset sees the cleared carry
        run_op(bfsu_pkg::OP_ROTATE_LEFT_CARRY, 8'h80, 8'h00, 3'h0);
    endtask : t_reset_mid_run

    // ----------------------------------------------------------------
    // Main sequence and guard
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(negedge i_mclk);
        i_reset = 1'b0;
        check("result", o_result, `BFSU_RESULT_RESET);
        expect_out(8'h00, 1'b0);
        t_shifts();
        t_flags();
        t_bits();
        t_back_to_back();
        t_reset_mid_run();
        wrap_up();
    end

    initial begin
        repeat (5000) @(posedge i_mclk);
        n_fail++;
        wrap_up();
    end
endmodule : tb_top
